// file: rtl/alu_consts.svh
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

`define NUM_REGS      32
`define REG_IDX_W     5
`define DATA_W        8
`define IO_ADDR_W     6
`define IO_BIT_LAST   6'h1F
`define LOCAL_IO_ADDR 6'h0E
`define W1C_MASK      8'hC0
`define PAIR_BASE     5'h18
`define BYTE_MSB      7
`define NIB_MSB       3
`define FLAG_C        0
`define FLAG_Z        1
`define FLAG_N        2
`define FLAG_V        3
`define FLAG_S        4
`define FLAG_H        5
`define FLAGS_RST     8'h00
`define BYTE_RST      8'h00
`define BYTE_ZERO     8'h00
`define WORD_ZERO     16'h0000
`define BIT_ONE       8'h01

`endif

// file: rtl/alu_pkg.sv
`include "alu_consts.svh"

package alu_pkg;

    typedef enum logic [2:0] {
        op_add,
        op_adc,
        op_word_immediate_add,
        op_set_io_bit,
        op_clear_io_bit
    } op_t;

    typedef enum logic [1:0] {
        st_idle,
        st_word_high,
        st_io_read
    } state_t;

    typedef struct packed {
        logic [`NUM_REGS-1:0][`DATA_W-1:0] regs;
        logic [`DATA_W-1:0]                sreg;
        state_t                            state;
        logic                              ready;
        logic                              done;
        logic                              error;
        logic [`REG_IDX_W-1:0]             pair_lo;
        logic                              low_carry;
        logic                              io_local;
        logic                              io_set;
        logic [2:0]                        io_bit;
        logic                              io_rd_en;
        logic                              io_wr_en;
        logic [`IO_ADDR_W-1:0]             io_addr;
        logic [`DATA_W-1:0]                io_wr_data;
        logic                              lf_wr_en;
        logic [`DATA_W-1:0]                lf_wr_data;
        logic [`DATA_W-1:0]                dbg_data;
    } core_state_t;

    typedef struct packed {
        logic [`DATA_W-1:0] flags;
    } flag_state_t;

endpackage

// file: rtl/local_flag_if.sv
`timescale 1ns/1ps
`include "alu_consts.svh"

interface local_flag_if;
    logic               wr_en;
    logic [`DATA_W-1:0] wr_data;
    logic [`DATA_W-1:0] flags;

    modport core (output wr_en, output wr_data, input flags);
    modport unit (input wr_en, input wr_data, output flags);
endinterface

// file: rtl/io_flag_unit.sv
`timescale 1ns/1ps
`include "alu_consts.svh"

module io_flag_unit #(
    parameter logic [`DATA_W-1:0] W1C_MASK = `W1C_MASK
) (
    input  wire logic               clk_sys,  // Core clock
    input  wire logic               rst_n,    // Async reset, active low
    input  wire logic [`DATA_W-1:0] flag_set, // Event pulses per bit
    local_flag_if.unit              lf        // Write port and flag view
);

    alu_pkg::flag_state_t st_reg;
    alu_pkg::flag_state_t st_next;
    logic [`DATA_W-1:0]   clr_mask;
    logic [`DATA_W-1:0]   plain_bits;

    always_comb
    begin
        st_next    = st_reg;
        clr_mask   = lf.wr_en ? (lf.wr_data & W1C_MASK) : `BYTE_ZERO;
        plain_bits = lf.wr_en ? (lf.wr_data & ~W1C_MASK) : (st_reg.flags & ~W1C_MASK);
        // Event set beats a same-cycle clear
        st_next.flags = plain_bits
                      | (((st_reg.flags & ~clr_mask) | flag_set) & W1C_MASK);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '{flags: `BYTE_RST};
        else
            st_reg <= st_next;
    end

    assign lf.flags = st_reg.flags;

endmodule // io_flag_unit

// file: rtl/add_and_io_bit_alu.sv
`timescale 1ns/1ps
`include "alu_consts.svh"

module add_and_io_bit_alu #(
    parameter logic [`IO_ADDR_W-1:0] LOCAL_IO_ADDR = `LOCAL_IO_ADDR,
    parameter logic [`DATA_W-1:0]    W1C_MASK      = `W1C_MASK
) (
    input  wire logic                  clk_sys,     // Core clock, 50 MHz
    input  wire logic                  rst_n,       // Async reset, active low
    input  wire logic                  op_valid,    // Operation request
    input  wire alu_pkg::op_t          op_code,     // Operation kind
    input  wire logic [`REG_IDX_W-1:0] op_dst,      // Destination register
    input  wire logic [`REG_IDX_W-1:0] op_src,      // source_register index
    input  wire logic [1:0]            op_pair,     // Pair select, 24..30
    input  wire logic [5:0]            op_imm,      // Word immediate
    input  wire logic [`IO_ADDR_W-1:0] op_io_addr,  // I/O address for bit ops
    input  wire logic [2:0]            op_bit,      // Bit number for bit ops
    output logic                       op_ready,    // Request taken when high
    output logic                       op_done,     // One-cycle completion
    output logic                       op_error,    // One-cycle refusal
    output logic [`DATA_W-1:0]         sreg_out,    // Status flags
    input  wire logic [`REG_IDX_W-1:0] dbg_idx,     // Register view index
    output logic [`DATA_W-1:0]         dbg_data,    // Register view data
    output logic                       io_rd_en,    // External I/O read
    output logic [`IO_ADDR_W-1:0]      io_addr,     // External I/O address
    input  wire logic [`DATA_W-1:0]    io_rd_data,  // External read data
    output logic                       io_wr_en,    // External I/O write
    output logic [`DATA_W-1:0]         io_wr_data,  // External write data
    input  wire logic [`DATA_W-1:0]    flag_set,    // Local flag events
    output logic [`DATA_W-1:0]         local_flags  // Local flag register
);

    alu_pkg::core_state_t st_reg;
    alu_pkg::core_state_t st_next;
    local_flag_if         lf ();

    logic [`DATA_W-1:0]    a;
    logic [`DATA_W-1:0]    b;
    logic [`DATA_W-1:0]    r;
    logic [`DATA_W:0]      sum9;
    logic                  cin;
    logic [`REG_IDX_W-1:0] lo_idx;
    logic [`REG_IDX_W-1:0] hi_idx;
    logic [15:0]           word_res;
    logic [`DATA_W-1:0]    rd_byte;
    wire  [`DATA_W-1:0]    bit_mask;
    logic                  n_f;
    logic                  v_f;
    logic                  h_f;
    logic                  c_f;
    logic                  z_f;

    io_flag_unit #(
        .W1C_MASK (W1C_MASK)
    ) u_flags (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .flag_set (flag_set),
        .lf       (lf.unit)
    );

    // One-hot select of the bit that a bit op sets or clears
    for (genvar gi = 0; gi < `DATA_W; gi++)
    begin : g_bit_sel
        assign bit_mask[gi] = (st_reg.io_bit == 3'(gi));
    end

    always_comb
    begin
        st_next          = st_reg;
        st_next.done     = 1'b0;
        st_next.error    = 1'b0;
        st_next.io_rd_en = 1'b0;
        st_next.io_wr_en = 1'b0;
        st_next.lf_wr_en = 1'b0;
        a        = `BYTE_ZERO;
        b        = `BYTE_ZERO;
        cin      = 1'b0;
        sum9     = {1'b0, `BYTE_ZERO};
        r        = `BYTE_ZERO;
        // Pairs start at the pair base and step by two registers
        lo_idx   = `REG_IDX_W'(`PAIR_BASE + {op_pair, 1'b0});
        hi_idx   = `REG_IDX_W'(st_reg.pair_lo + 1'b1);
        word_res = `WORD_ZERO;
        rd_byte  = st_reg.io_local ? lf.flags : io_rd_data;
        n_f      = 1'b0;
        v_f      = 1'b0;
        h_f      = 1'b0;
        c_f      = 1'b0;
        z_f      = 1'b0;

        unique case (st_reg.state)
            alu_pkg::st_idle:
            begin
                // Requests wait while a two-cycle op runs
                if (op_valid && st_reg.ready)
                begin
                    unique case (op_code)
                        alu_pkg::op_add,
                        alu_pkg::op_adc:
                        begin
                            a    = st_reg.regs[op_dst];
                            b    = st_reg.regs[op_src];
                            cin  = (op_code == alu_pkg::op_adc) & st_reg.sreg[`FLAG_C];
                            sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
                            r    = sum9[`DATA_W-1:0];
                            n_f  = r[`BYTE_MSB];
                            v_f  = (a[`BYTE_MSB] & b[`BYTE_MSB] & ~r[`BYTE_MSB])
                                 | (~a[`BYTE_MSB] & ~b[`BYTE_MSB] & r[`BYTE_MSB]);
                            h_f  = (a[`NIB_MSB] & b[`NIB_MSB])
                                 | (b[`NIB_MSB] & ~r[`NIB_MSB])
                                 | (~r[`NIB_MSB] & a[`NIB_MSB]);
                            c_f  = sum9[`DATA_W];
                            z_f  = (r == `BYTE_ZERO);
                            st_next.regs[op_dst]    = r;
                            st_next.sreg[`FLAG_H]   = h_f;
                            st_next.sreg[`FLAG_C]   = c_f;
                            st_next.sreg[`FLAG_N]   = n_f;
                            st_next.sreg[`FLAG_V]   = v_f;
                            st_next.sreg[`FLAG_S]   = n_f ^ v_f;
                            st_next.sreg[`FLAG_Z]   = z_f;
                            st_next.done            = 1'b1;
                        end
                        alu_pkg::op_word_immediate_add:
                        begin
                            a    = st_reg.regs[lo_idx];
                            // Low byte now, high byte with its carry on the next edge
                            sum9 = {1'b0, a} + {3'b000, op_imm};
                            st_next.regs[lo_idx] = sum9[`DATA_W-1:0];
                            st_next.low_carry    = sum9[`DATA_W];
                            st_next.pair_lo      = lo_idx;
                            st_next.ready        = 1'b0;
                            st_next.state        = alu_pkg::st_word_high;
                        end
                        alu_pkg::op_set_io_bit,
                        alu_pkg::op_clear_io_bit:
                        begin
                            // Above the low I/O range: refused with no access
                            if (op_io_addr > `IO_BIT_LAST)
                                st_next.error = 1'b1;
                            else
                            begin
                                // The local register never goes out on the I/O strobes
                                st_next.io_local = (op_io_addr == LOCAL_IO_ADDR);
                                st_next.io_set   = (op_code == alu_pkg::op_set_io_bit);
                                st_next.io_bit   = op_bit;
                                st_next.io_addr  = op_io_addr;
                                st_next.io_rd_en = (op_io_addr != LOCAL_IO_ADDR);
                                st_next.ready    = 1'b0;
                                st_next.state    = alu_pkg::st_io_read;
                            end
                        end
                        // Codes outside the set are refused
                        default:
                            st_next.error = 1'b1;
                    endcase
                end
            end
            alu_pkg::st_word_high:
            begin
                // Zero flag covers the whole word, low byte already written
                a        = st_reg.regs[hi_idx];
                r        = `DATA_W'(a + {7'h00, st_reg.low_carry});
                word_res = {r, st_reg.regs[st_reg.pair_lo]};
                n_f      = r[`BYTE_MSB];
                v_f      = ~a[`BYTE_MSB] & r[`BYTE_MSB];
                st_next.regs[hi_idx]  = r;
                st_next.sreg[`FLAG_C] = a[`BYTE_MSB] & ~r[`BYTE_MSB];
                st_next.sreg[`FLAG_N] = n_f;
                st_next.sreg[`FLAG_V] = v_f;
                st_next.sreg[`FLAG_S] = n_f ^ v_f;
                st_next.sreg[`FLAG_Z] = (word_res == `WORD_ZERO);
                st_next.done          = 1'b1;
                st_next.ready         = 1'b1;
                st_next.state         = alu_pkg::st_idle;
            end
            alu_pkg::st_io_read:
            begin
                // The whole byte goes back, so set W1C flags are cleared too, except the bit that a clear op names
                r = st_reg.io_set ? (rd_byte | bit_mask) : (rd_byte & ~bit_mask);
                st_next.io_wr_data = r;
                st_next.lf_wr_data = r;
                st_next.io_wr_en   = ~st_reg.io_local;
                st_next.lf_wr_en   = st_reg.io_local;
                st_next.done       = 1'b1;
                st_next.ready      = 1'b1;
                st_next.state      = alu_pkg::st_idle;
            end
        endcase

        // Register view lags its index by one cycle
        st_next.dbg_data = st_reg.regs[dbg_idx];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg            <= '0;
            st_reg.sreg       <= `FLAGS_RST;
            st_reg.state      <= alu_pkg::st_idle;
            // Ready from reset, so the first edge after release can take a request
            st_reg.ready      <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // Strobes and pulses are cleared by the defaults, so each lasts one cycle
    assign lf.wr_en    = st_reg.lf_wr_en;
    assign lf.wr_data  = st_reg.lf_wr_data;
    assign op_ready    = st_reg.ready;
    assign op_done     = st_reg.done;
    assign op_error    = st_reg.error;
    assign sreg_out    = st_reg.sreg;
    assign dbg_data    = st_reg.dbg_data;
    assign io_rd_en    = st_reg.io_rd_en;
    assign io_addr     = st_reg.io_addr;
    assign io_wr_en    = st_reg.io_wr_en;
    assign io_wr_data  = st_reg.io_wr_data;
    assign local_flags = lf.flags;

endmodule // add_and_io_bit_alu

// file: tb/add_and_io_bit_alu_asserts.sv
`timescale 1ns/1ps
module add_and_io_bit_alu_asserts #(
    parameter logic [5:0] LOCAL_IO_ADDR = 6'h0E,
    parameter logic [7:0] W1C_MASK      = 8'hC0
) (
    input wire logic         clk_sys,     // Clock
    input wire logic         rst_n,       // Reset
    input wire logic         op_valid,    // Request
    input wire alu_pkg::op_t op_code,     // Kind
    input wire logic [5:0]   op_io_addr,  // Bit op address
    input wire logic [2:0]   op_bit,      // Bit number
    input wire logic         op_ready,    // Idle
    input wire logic         op_done,     // Done
    input wire logic         op_error,    // Refusal
    input wire logic [7:0]   sreg_out,    // Flags
    input wire logic         io_rd_en,    // Read strobe
    input wire logic [5:0]   io_addr,     // Address
    input wire logic [7:0]   io_rd_data,  // Read data
    input wire logic         io_wr_en,    // Write strobe
    input wire logic [7:0]   io_wr_data,  // Write data
    input wire logic [7:0]   flag_set,    // Flag events
    input wire logic [7:0]   local_flags  // Local flags
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic take;
    logic bit_op;
    assign take   = op_valid && op_ready;
    assign bit_op = take && op_code inside {alu_pkg::op_set_io_bit, alu_pkg::op_clear_io_bit};

    property p_add;
        take && op_code inside {alu_pkg::op_add, alu_pkg::op_adc} |=> op_done && op_ready;
    endproperty
    a_add: assert property (p_add) else $error("add not one cycle");
    property p_word;
        take && op_code == alu_pkg::op_word_immediate_add
            |=> !op_ready && !op_done ##1 op_done && op_ready;
    endproperty
    a_word: assert property (p_word) else $error("word add not two cycles");
    property p_bad;
        bit_op && op_io_addr > 6'h1F |=> op_error && !io_rd_en && !op_done && op_ready;
    endproperty
    a_bad: assert property (p_bad) else $error("high address not refused");
    property p_ext;
        bit_op && op_io_addr <= 6'h1F && op_io_addr != LOCAL_IO_ADDR
            |=> io_rd_en && io_addr == $past(op_io_addr) ##1 io_wr_en && op_done;
    endproperty
    a_ext: assert property (p_ext) else $error("bit op access order");
    property p_wbyte;
        bit_op && op_io_addr <= 6'h1F && op_io_addr != LOCAL_IO_ADDR |=> ##1
            io_wr_data == ($past(op_code, 2) == alu_pkg::op_set_io_bit
                ? $past(io_rd_data) | (8'h01 << $past(op_bit, 2))
                : $past(io_rd_data) & ~(8'h01 << $past(op_bit, 2)));
    endproperty
    a_wbyte: assert property (p_wbyte) else $error("bit op byte wrong");
    property p_local;
        bit_op && op_io_addr == LOCAL_IO_ADDR |=> !io_rd_en ##1 !io_wr_en && op_done;
    endproperty
    a_local: assert property (p_local) else $error("local op went outside");
    property p_fset;
        |(flag_set & W1C_MASK) |=> (local_flags & $past(flag_set) & W1C_MASK)
            == ($past(flag_set) & W1C_MASK);
    endproperty
    a_fset: assert property (p_fset) else $error("flag not set");
    property p_frise;
        (local_flags & ~$past(local_flags) & ~$past(flag_set) & W1C_MASK) == 8'h00;
    endproperty
    a_frise: assert property (p_frise) else $error("flag set by write");
    property p_sreg;
        sreg_out[7:6] == 2'b00;
    endproperty
    a_sreg: assert property (p_sreg) else $error("unused flag bits set");
endmodule // add_and_io_bit_alu_asserts

bind add_and_io_bit_alu add_and_io_bit_alu_asserts #(
    .LOCAL_IO_ADDR(LOCAL_IO_ADDR), .W1C_MASK(W1C_MASK)
) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_io_addr(op_io_addr), .op_bit(op_bit), .op_ready(op_ready), .op_done(op_done),
    .op_error(op_error), .sreg_out(sreg_out), .io_rd_en(io_rd_en), .io_addr(io_addr),
    .io_rd_data(io_rd_data), .io_wr_en(io_wr_en), .io_wr_data(io_wr_data),
    .flag_set(flag_set), .local_flags(local_flags)
);

// file: tb/add_and_io_bit_alu_tb.sv
`timescale 1ns/1ps
`include "alu_consts.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end

module add_and_io_bit_alu_tb;
    logic         clk_sys, rst_n, op_valid, op_ready, op_done, op_error, io_rd_en, io_wr_en;
    alu_pkg::op_t op_code;
    logic [4:0]   op_dst, op_src, dbg_idx;
    logic [1:0]   op_pair;
    logic [5:0]   op_imm, op_io_addr, io_addr;
    logic [2:0]   op_bit;
    logic [7:0]   sreg_out, dbg_data, io_rd_data, io_wr_data, flag_set, local_flags, m_sreg, m_loc;
    logic [7:0]   m_regs [32];
    int           comparisons, miscompares, k;

    add_and_io_bit_alu dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
        .op_dst(op_dst), .op_src(op_src), .op_pair(op_pair), .op_imm(op_imm),
        .op_io_addr(op_io_addr), .op_bit(op_bit), .op_ready(op_ready), .op_done(op_done),
        .op_error(op_error), .sreg_out(sreg_out), .dbg_idx(dbg_idx), .dbg_data(dbg_data),
        .io_rd_en(io_rd_en), .io_addr(io_addr), .io_rd_data(io_rd_data), .io_wr_en(io_wr_en),
        .io_wr_data(io_wr_data), .flag_set(flag_set), .local_flags(local_flags)
    );

    function automatic logic [15:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [7:0] f;
        s = a + b + ci;
        f = 8'h00;
        f[`FLAG_C] = s[8];
        f[`FLAG_Z] = s[7:0] == 8'h00;
        f[`FLAG_N] = s[7];
        f[`FLAG_V] = a[7] & b[7] & ~s[7] | ~a[7] & ~b[7] & s[7];
        f[`FLAG_S] = f[`FLAG_N] ^ f[`FLAG_V];
        f[`FLAG_H] = a[3] & b[3] | b[3] & ~s[3] | ~s[3] & a[3];
        return {f, s[7:0]};
    endfunction

    task automatic send(alu_pkg::op_t c, logic [4:0] d, logic [4:0] s, logic [1:0] p,
                        logic [5:0] im, logic [5:0] a, logic [2:0] b);
        op_code = c;
        op_dst = d;
        op_src = s;
        op_pair = p;
        op_imm = im;
        op_io_addr = a;
        op_bit = b;
        op_valid = 1'b1;
        @(posedge clk_sys);
        #1;
    endtask

    // Leaves the request raised so adds can run back to back
    task automatic do_add(logic adc, logic [4:0] d, logic [4:0] s);
        logic [15:0] r;
        r = add8(m_regs[d], m_regs[s], adc & m_sreg[`FLAG_C]);
        send(adc ? alu_pkg::op_adc : alu_pkg::op_add, d, s, 2'h0, 6'h00, 6'h00, 3'h0);
        m_regs[d] = r[7:0];
        m_sreg = r[15:8];
        `CHK(op_done, 1'b1)
        `CHK(sreg_out, m_sreg)
    endtask

    task automatic do_word(logic [1:0] p, logic [5:0] im);
        logic [4:0]  lo;
        logic [15:0] w;
        lo = `PAIR_BASE + {2'b00, p, 1'b0};
        w = {m_regs[lo + 5'h01], m_regs[lo]} + {10'h000, im};
        send(alu_pkg::op_word_immediate_add, 5'h00, 5'h00, p, im, 6'h00, 3'h0);
        op_valid = 1'b0;
        `CHK(op_ready, 1'b0)
        @(posedge clk_sys);
        #1;
        m_sreg = m_sreg & 8'h20;
        m_sreg[`FLAG_C] = ~w[15] & m_regs[lo + 5'h01][7];
        m_sreg[`FLAG_V] = w[15] & ~m_regs[lo + 5'h01][7];
        m_sreg[`FLAG_N] = w[15];
        m_sreg[`FLAG_S] = m_sreg[`FLAG_N] ^ m_sreg[`FLAG_V];
        m_sreg[`FLAG_Z] = w == 16'h0000;
        {m_regs[lo + 5'h01], m_regs[lo]} = w;
        `CHK(op_done, 1'b1)
        `CHK(sreg_out, m_sreg)
    endtask

    task automatic do_bit(logic set, logic [5:0] a, logic [2:0] b, logic [7:0] rd);
        logic [7:0] v;
        send(set ? alu_pkg::op_set_io_bit : alu_pkg::op_clear_io_bit, 5'h00, 5'h00, 2'h0,
             6'h00, a, b);
        op_valid = 1'b0;
        if (a > `IO_BIT_LAST)
        begin
            `CHK(op_error, 1'b1)
            `CHK(io_rd_en, 1'b0)
            `CHK(op_ready, 1'b1)
            @(posedge clk_sys);
            #1;
        end
        else if (a == `LOCAL_IO_ADDR)
        begin
            v = set ? m_loc | (8'h01 << b) : m_loc & ~(8'h01 << b);
            `CHK(io_rd_en, 1'b0)
            @(posedge clk_sys);
            #1;
            `CHK(op_done, 1'b1)
            `CHK(io_wr_en, 1'b0)
            @(posedge clk_sys);
            #1;
            m_loc = (v & ~`W1C_MASK) | (m_loc & `W1C_MASK & ~v);
            `CHK(local_flags, m_loc)
        end
        else
        begin
            `CHK(io_addr, a)
            `CHK(io_rd_en, 1'b1)
            io_rd_data = rd;
            @(posedge clk_sys);
            #1;
            `CHK(io_wr_en, 1'b1)
            `CHK(op_done, 1'b1)
            `CHK(io_wr_data, set ? rd | (8'h01 << b) : rd & ~(8'h01 << b))
        end
    endtask

    task automatic wrap_up();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial
    begin
        {rst_n, op_valid, op_dst, op_src, dbg_idx, op_pair, op_imm, op_io_addr, op_bit} = '0;
        op_code = alu_pkg::op_add;
        io_rd_data = 8'h00;
        flag_set = 8'h00;
        m_sreg = 8'h00;
        m_loc = 8'h00;
        foreach (m_regs[i]) m_regs[i] = 8'h00;
        void'($urandom(32'h49DB));
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        do_add(1'b0, 5'h00, 5'h00);
        do_word(2'h3, 6'h00);
        do_word(2'h0, 6'h3F);
        do_bit(1'b1, 6'h1F, 3'h7, 8'h5A);
        do_bit(1'b0, 6'h20, 3'h0, 8'h00);
        send(alu_pkg::op_t'(3'h7), 5'h00, 5'h00, 2'h0, 6'h00, 6'h00, 3'h0);
        op_valid = 1'b0;
        `CHK(op_error, 1'b1)
        `CHK(op_done, 1'b0)
        flag_set = 8'hC0;
        @(posedge clk_sys);
        #1;
        flag_set = 8'h00;
        m_loc = m_loc | 8'hC0;
        `CHK(local_flags, m_loc)
        do_bit(1'b1, `LOCAL_IO_ADDR, 3'h0, 8'h00);
        repeat (400)
        begin
            k = $urandom_range(0, 3);
            if (k < 2)
                do_add(k[0], 5'($urandom), 5'($urandom));
            else if (k == 2)
                do_word(2'($urandom), 6'($urandom));
            else
                do_bit(1'($urandom), 6'($urandom), 3'($urandom), 8'($urandom));
        end
        op_valid = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            dbg_idx = 5'(i);
            @(posedge clk_sys);
            #1;
            `CHK(dbg_data, m_regs[i])
        end
        wrap_up();
    end
endmodule // add_and_io_bit_alu_tb
